// ===== rtl/sem_host.sv
// host that claims, releases and reads the eight semaphore flags
`timescale 1ns/1ps
module sem_host (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // user command
    input wire logic cmd_valid_in,
    input wire sem_host_pkg::cmd_s cmd_in,
    output logic ready_out,
    output logic done_out,
    output sem_host_pkg::result_s result_out,
    output logic [sem_host_pkg::FLAG_COUNT-1:0] held_out,
    output logic [sem_host_pkg::FLAG_COUNT-1:0] pending_out,
    // device port pins
    output logic ram_enable_n_out,
    output logic flag_space_select_n_out,
    output logic output_enable_n_out,
    output logic write_n_out,
    output logic [sem_host_pkg::INDEX_W-1:0] flag_index_lines_out,
    input wire logic [sem_host_pkg::DATA_W-1:0] data_in,
    output logic [sem_host_pkg::DATA_W-1:0] data_out,
    output logic data_oe_out
);
    typedef enum {S_IDLE, S_WSET, S_WPUL, S_WHLD, S_WGAP, S_RACC, S_RGAP,
        S_DONE} state_e;
    localparam int TW = sem_host_pkg::TIMER_W;
    localparam int IW = sem_host_pkg::INDEX_W;
    localparam int NF = sem_host_pkg::FLAG_COUNT;
    localparam int DW = sem_host_pkg::DATA_W;

    state_e state_q, state_d;
    sem_host_pkg::op_e op_q;
    logic [IW-1:0] idx_q, idx_d;
    logic wval_q, wval_d;
    logic wrote_q;
    logic sem_n_q, oe_n_q, we_n_q, doe_q, ce_n_q, done_q;
    logic [NF-1:0] held_q, pending_q;
    sem_host_pkg::result_s res_q;
    logic [TW-1:0] len_d;
    logic ready_q;

    wire expired;
    wire take = state_q == S_IDLE && cmd_valid_in;
    wire start = state_d != state_q;
    wire init_more = op_q == sem_host_pkg::OP_INIT &&
        idx_q != sem_host_pkg::LAST_INDEX;
    wire rd_flag = data_in[sem_host_pkg::FLAG_BIT];
    wire rd_split = data_in != {DW{rd_flag}};
    wire capture = state_q == S_RACC && expired;
    wire sem_d = state_d inside {S_WSET, S_WPUL, S_WHLD, S_RACC};
    wire oe_d = state_d == S_RACC;
    wire we_d = state_d == S_WPUL;
    wire doe_d = state_d inside {S_WSET, S_WPUL, S_WHLD};

    initial
    begin
        if (sem_host_pkg::ACCESS_CYC >= (1 << TW) ||
            sem_host_pkg::WPULSE_CYC >= (1 << TW))
            $error("phase timer too narrow for timing counts");
    end

    phase_timer #(.W(TW)) u_timer (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .start_in(start),
        .len_in(len_d),
        .expired_out(expired)
    );

    always_comb
    begin
        state_d = state_q;
        idx_d = idx_q;
        wval_d = wval_q;
        case (state_q)
            S_IDLE:
                if (cmd_valid_in)
                begin
                    idx_d = cmd_in.index;
                    wval_d = cmd_in.op != sem_host_pkg::OP_TRY;
                    if (cmd_in.op == sem_host_pkg::OP_INIT)
                        idx_d = '0;
                    // a request always writes before it reads
                    state_d = cmd_in.op == sem_host_pkg::OP_READ ?
                        S_RACC : S_WSET;
                end
            S_WSET:
                if (expired)
                    state_d = S_WPUL;
            S_WPUL:
                if (expired)
                    state_d = S_WHLD;
            S_WHLD:
                if (expired)
                    state_d = S_WGAP;
            S_WGAP:
                if (expired)
                begin
                    if (init_more)
                    begin
                        idx_d = idx_q + IW'(1);
                        state_d = S_WSET;
                    end
                    else if (op_q == sem_host_pkg::OP_TRY)
                        state_d = S_RACC;
                    else
                        state_d = S_DONE;
                end
            S_RACC:
                if (expired)
                    state_d = S_RGAP;
            // select and enable go high so the next read relatches
            S_RGAP:
                if (expired)
                    state_d = S_DONE;
            S_DONE:
                state_d = S_IDLE;
            default:
                state_d = S_IDLE;
        endcase
    end

    always_comb
    begin
        case (state_d)
            S_WSET: len_d = TW'(sem_host_pkg::SETUP_CYC);
            S_WPUL: len_d = TW'(sem_host_pkg::WPULSE_CYC);
            S_WHLD: len_d = TW'(sem_host_pkg::HOLD_CYC);
            S_RACC: len_d = TW'(sem_host_pkg::ACCESS_CYC);
            default: len_d = TW'(sem_host_pkg::GAP_CYC);
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_q <= S_IDLE;
            idx_q <= '0;
            wval_q <= 1'b1;
            op_q <= sem_host_pkg::OP_READ;
        end
        else
        begin
            state_q <= state_d;
            idx_q <= idx_d;
            wval_q <= wval_d;
            if (take)
                op_q <= cmd_in.op;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            wrote_q <= 1'b0;
        else if (take)
            wrote_q <= 1'b0;
        else if (state_q == S_WPUL)
            wrote_q <= 1'b1;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            ready_q <= 1'b1;
        else
            ready_q <= state_d == S_IDLE;
    end

    // pins are registered from the next state: glitch-free strobes
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ce_n_q <= 1'b1;
            sem_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            doe_q <= 1'b0;
        end
        else
        begin
            ce_n_q <= 1'b1;
            sem_n_q <= !sem_d;
            oe_n_q <= !oe_d;
            we_n_q <= !we_d;
            doe_q <= doe_d;
        end
    end

    // flag value on bit zero; upper bits copy it so any bit may be read
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            data_out <= {DW{1'b1}};
        else
            data_out <= {DW{wval_d}};
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            flag_index_lines_out <= '0;
        else
            flag_index_lines_out <= idx_d;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            res_q <= '0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= state_d == S_DONE;
            if (capture)
            begin
                res_q.flag <= rd_flag;
                res_q.split <= rd_split;
                res_q.granted <= op_q == sem_host_pkg::OP_TRY && !rd_flag;
            end
            else if (take)
                res_q <= '0;
        end
    end

    // ownership and outstanding requests as this port sees them
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            held_q <= '0;
            pending_q <= '0;
        end
        else if (capture && op_q == sem_host_pkg::OP_TRY)
        begin
            held_q[idx_q] <= !rd_flag;
            pending_q[idx_q] <= rd_flag;
        end
        else if (capture)
        begin
            held_q[idx_q] <= !rd_flag;
            pending_q[idx_q] <= pending_q[idx_q] && rd_flag;
        end
        else if (state_q == S_WPUL && wval_q)
        begin
            held_q[idx_q] <= 1'b0;
            pending_q[idx_q] <= 1'b0;
        end
    end

    assign ram_enable_n_out = ce_n_q;
    assign flag_space_select_n_out = sem_n_q;
    assign output_enable_n_out = oe_n_q;
    assign write_n_out = we_n_q;
    assign data_oe_out = doe_q;
    assign done_out = done_q;
    assign ready_out = ready_q;
    assign result_out = res_q;
    assign held_out = held_q;
    assign pending_out = pending_q;

    sequence s_write_strobe;
        !write_n_out && !flag_space_select_n_out && data_oe_out;
    endsequence

    sequence s_read_window;
        !output_enable_n_out && !flag_space_select_n_out;
    endsequence

    property p_ce_high;
        @(posedge clk_in) disable iff (!reset_n_in)
        ram_enable_n_out;
    endproperty
    a_ce_high: assert property (p_ce_high)
        else $error("ram enable dropped during flag access");

    property p_write_selected;
        @(posedge clk_in) disable iff (!reset_n_in)
        !write_n_out |-> s_write_strobe and output_enable_n_out;
    endproperty
    a_write_selected: assert property (p_write_selected)
        else $error("write strobe without flag select");

    property p_no_drive_on_read;
        @(posedge clk_in) disable iff (!reset_n_in)
        !output_enable_n_out |-> !data_oe_out;
    endproperty
    a_no_drive_on_read: assert property (p_no_drive_on_read)
        else $error("data driven while reading");

    property p_try_writes_zero;
        @(posedge clk_in) disable iff (!reset_n_in)
        s_write_strobe and op_q == sem_host_pkg::OP_TRY |->
            data_out[sem_host_pkg::FLAG_BIT] == 1'b0;
    endproperty
    a_try_writes_zero: assert property (p_try_writes_zero)
        else $error("request did not write zero");

    property p_init_writes_one;
        @(posedge clk_in) disable iff (!reset_n_in)
        s_write_strobe and op_q != sem_host_pkg::OP_TRY |->
            data_out[sem_host_pkg::FLAG_BIT] == 1'b1;
    endproperty
    a_init_writes_one: assert property (p_init_writes_one)
        else $error("release or init did not write one");

    property p_write_before_read;
        @(posedge clk_in) disable iff (!reset_n_in)
        s_read_window and op_q == sem_host_pkg::OP_TRY |-> wrote_q;
    endproperty
    a_write_before_read: assert property (p_write_before_read)
        else $error("request read before its write");

    property p_read_gap;
        @(posedge clk_in) disable iff (!reset_n_in)
        $rose(output_enable_n_out) |->
            output_enable_n_out [*2] ##1 (output_enable_n_out && done_out);
    endproperty
    a_read_gap: assert property (p_read_gap)
        else $error("read enable not deasserted between reads");

    property p_index_stable;
        @(posedge clk_in) disable iff (!reset_n_in)
        !flag_space_select_n_out && !$past(flag_space_select_n_out) |->
            $stable(flag_index_lines_out);
    endproperty
    a_index_stable: assert property (p_index_stable)
        else $error("flag index moved during access");

    property p_read_length;
        @(posedge clk_in) disable iff (!reset_n_in)
        $fell(output_enable_n_out) |->
            (!output_enable_n_out) [*5] ##1 output_enable_n_out;
    endproperty
    a_read_length: assert property (p_read_length)
        else $error("read window has wrong length");

    property p_fail_pending;
        @(posedge clk_in) disable iff (!reset_n_in)
        capture && op_q == sem_host_pkg::OP_TRY && rd_flag |=>
            pending_out[$past(idx_q)] && !held_out[$past(idx_q)];
    endproperty
    a_fail_pending: assert property (p_fail_pending)
        else $error("failed request not marked pending");
endmodule : sem_host

// ===== rtl/sem_host_pkg.sv
// constants and types for the semaphore-flag host controller
package sem_host_pkg;
    localparam int FLAG_COUNT = 8;
    localparam int INDEX_W = 3;
    localparam int DATA_W = 16;
    localparam int FLAG_BIT = 0;
    localparam logic [INDEX_W-1:0] LAST_INDEX = 3'h7;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int T_SETUP_NS = 10;
    localparam int T_WPULSE_NS = 20;
    localparam int T_HOLD_NS = 10;
    localparam int T_ACCESS_NS = 25;
    localparam int T_GAP_NS = 10;
    localparam int SETUP_CYC = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int WPULSE_CYC = (T_WPULSE_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int HOLD_CYC = (T_HOLD_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int ACCESS_CYC = (T_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int GAP_CYC = (T_GAP_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int TIMER_W = 4;

    typedef enum logic [1:0] {
        OP_READ,
        OP_TRY,
        OP_RELEASE,
        OP_INIT
    } op_e;

    typedef struct packed {
        op_e op;
        logic [INDEX_W-1:0] index;
    } cmd_s;

    typedef struct packed {
        logic granted;
        logic flag;
        logic split;
    } result_s;
endpackage : sem_host_pkg

// ===== rtl/phase_timer.sv
// down-counter that marks the end of one bus phase
`timescale 1ns/1ps
module phase_timer #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // control
    input wire logic start_in,
    input wire logic [W-1:0] len_in,
    // status
    output logic expired_out
);
    logic [W-1:0] count_q;
    logic expired_q;

    initial
    begin
        if (W < 2)
            $error("phase_timer width too small");
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            count_q <= '0;
        else if (start_in)
            count_q <= len_in;
        else if (count_q != '0)
            count_q <= count_q - W'(1);
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            expired_q <= 1'b0;
        else
            // registered one cycle early so a phase lasts len_in cycles
            expired_q <= start_in ? len_in == W'(1) : count_q == W'(2);
    end

    assign expired_out = expired_q;
endmodule : phase_timer

// ===== bench/sem_flag_device.sv
// behavioural two-port semaphore flag device for the host bench
`timescale 1ns/1ps
module sem_flag_device (
    // left port, wired to the host
    input wire logic l_ce_n_in,
    input wire logic l_sel_n_in,
    input wire logic l_oe_n_in,
    input wire logic l_we_n_in,
    input wire logic [2:0] l_idx_in,
    input wire logic [15:0] l_d_in,
    output logic [15:0] l_q_out,
    // right port, driven by the bench
    input wire logic r_sel_n_in,
    input wire logic r_oe_n_in,
    input wire logic r_we_n_in,
    input wire logic [2:0] r_idx_in,
    input wire logic r_d_in,
    output logic [15:0] r_q_out
);
    // power-up state is arbitrary: left holds every token
    logic [7:0] req_l = 8'h00;
    logic [7:0] req_r = 8'hff;
    logic [7:0] own_l = 8'hff;
    logic [7:0] own_r = 8'h00;
    logic [15:0] cap_l = 16'hffff;
    logic [15:0] cap_r = 16'hffff;
    wire rd_l = l_ce_n_in && !l_sel_n_in && !l_oe_n_in && l_we_n_in;
    wire rd_r = !r_sel_n_in && !r_oe_n_in && r_we_n_in;

    task automatic settle(input logic [2:0] i);
        if (own_l[i] && req_l[i]) own_l[i] = 1'b0;
        if (own_r[i] && req_r[i]) own_r[i] = 1'b0;
        // a waiting request takes over at once; a tie goes left
        if (!own_l[i] && !own_r[i])
        begin
            if (!req_l[i]) own_l[i] = 1'b1;
            else if (!req_r[i]) own_r[i] = 1'b1;
        end
    endtask : settle

    always @(posedge l_we_n_in)
        if (l_ce_n_in && !l_sel_n_in)
        begin
            req_l[l_idx_in] = l_d_in[0];
            settle(l_idx_in);
        end
    always @(posedge r_we_n_in)
        if (!r_sel_n_in)
        begin
            req_r[r_idx_in] = r_d_in;
            settle(r_idx_in);
        end
    // latched once per select/enable pair so a read cannot tear
    always @(posedge rd_l) cap_l = {16{!own_l[l_idx_in]}};
    always @(posedge rd_r) cap_r = {16{!own_r[r_idx_in]}};
    // released bus shows the inverse, never a held copy; no stall
    assign l_q_out = rd_l ? cap_l : ~cap_l;
    assign r_q_out = rd_r ? cap_r : ~cap_r;
endmodule : sem_flag_device

// ===== bench/dual_port_semaphore_flags_bench.sv
// self-checking bench for the semaphore flag host
`timescale 1ns/1ps
module dual_port_semaphore_flags_bench;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic cmd_valid_in = 1'b0;
    sem_host_pkg::cmd_s cmd_in = '0;
    sem_host_pkg::result_s result_out;
    logic ready_out, done_out, ram_enable_n_out, flag_space_select_n_out;
    logic output_enable_n_out, write_n_out, data_oe_out;
    logic [7:0] held_out, pending_out;
    logic [2:0] flag_index_lines_out;
    logic [15:0] data_in, data_out, dev_q, r_q;
    logic r_sel_n = 1'b1, r_oe_n = 1'b1, r_we_n = 1'b1, r_d = 1'b1;
    logic [2:0] r_idx = 3'h0;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #2.5 clk_in = ~clk_in;
    assign data_in = data_oe_out ? data_out : dev_q;

    sem_host dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .ready_out(ready_out),
        .done_out(done_out), .result_out(result_out), .held_out(held_out),
        .pending_out(pending_out), .ram_enable_n_out(ram_enable_n_out),
        .flag_space_select_n_out(flag_space_select_n_out),
        .output_enable_n_out(output_enable_n_out),
        .write_n_out(write_n_out), .flag_index_lines_out(flag_index_lines_out),
        .data_in(data_in), .data_out(data_out), .data_oe_out(data_oe_out));

    sem_flag_device partner (.l_ce_n_in(ram_enable_n_out),
        .l_sel_n_in(flag_space_select_n_out), .l_oe_n_in(output_enable_n_out),
        .l_we_n_in(write_n_out), .l_idx_in(flag_index_lines_out),
        .l_d_in(data_out), .l_q_out(dev_q), .r_sel_n_in(r_sel_n),
        .r_oe_n_in(r_oe_n), .r_we_n_in(r_we_n), .r_idx_in(r_idx),
        .r_d_in(r_d), .r_q_out(r_q));

    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("mismatches %0d samples_checked %0d", mismatches,
            samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick

    task automatic host(input sem_host_pkg::op_e op, input logic [2:0] idx);
        int n;
        n = 0;
        while (ready_out !== 1'b1 && n < 200)
        begin
            tick(1);
            n++;
        end
        cmd_in.op = op;
        cmd_in.index = idx;
        cmd_valid_in = 1'b1;
        tick(1);
        cmd_valid_in = 1'b0;
        n = 0;
        while (done_out !== 1'b1 && n < 200)
        begin
            tick(1);
            n++;
        end
        if (n >= 200) mismatches++;
    endtask : host

    // read or try, then compare the flag seen by the host
    task automatic host_rd(input sem_host_pkg::op_e op, input logic [2:0] idx,
        input logic exp);
        host(op, idx);
        check("host flag", {15'h0, result_out.flag}, {15'h0, exp});
        check("split", {15'h0, result_out.split}, 16'h0);
        if (op == sem_host_pkg::OP_TRY)
            check("granted", {15'h0, result_out.granted}, {15'h0, !exp});
    endtask : host_rd

    task automatic r_write(input logic [2:0] idx, input logic b);
        r_idx = idx;
        r_d = b;
        r_sel_n = 1'b0;
        tick(2);
        r_we_n = 1'b0;
        tick(4);
        r_we_n = 1'b1;
        tick(2);
        r_sel_n = 1'b1;
        tick(1);
    endtask : r_write

    task automatic r_open(input logic [2:0] idx);
        r_idx = idx;
        r_sel_n = 1'b0;
        r_oe_n = 1'b0;
        tick(5);
    endtask : r_open

    task automatic r_close();
        r_sel_n = 1'b1;
        r_oe_n = 1'b1;
        tick(2);
    endtask : r_close

    task automatic r_read(input logic [2:0] idx, input logic exp);
        r_open(idx);
        check("right flag", r_q, {16{exp}});
        r_close();
    endtask : r_read

    // the RAM array must stay deselected whenever flag space is touched
    always @(negedge clk_in)
        if (reset_n_in && flag_space_select_n_out === 1'b0)
            check("ram enable", {15'h0, ram_enable_n_out}, 16'h1);

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            mismatches++;
            final_report();
        end
    end

    initial
    begin
        tick(8);
        reset_n_in = 1'b1;
        check("ready", {15'h0, ready_out}, 16'h1);
        host_rd(sem_host_pkg::OP_READ, 3'h3, 1'b0);
        host(sem_host_pkg::OP_INIT, 3'h0);
        for (int i = 0; i < 8; i++)
        begin
            host_rd(sem_host_pkg::OP_TRY, 3'(i), 1'b0);
            r_read(3'(i), 1'b1);
            host(sem_host_pkg::OP_RELEASE, 3'(i));
            r_read(3'(i), 1'b1);
        end
        host_rd(sem_host_pkg::OP_TRY, 3'h2, 1'b0);
        check("held", {8'h0, held_out}, 16'h0004);
        r_write(3'h2, 1'b0);
        host_rd(sem_host_pkg::OP_READ, 3'h2, 1'b0);
        r_read(3'h2, 1'b1);
        host(sem_host_pkg::OP_RELEASE, 3'h2);
        r_read(3'h2, 1'b0);
        host_rd(sem_host_pkg::OP_READ, 3'h2, 1'b1);
        check("held", {8'h0, held_out}, 16'h0000);
        host_rd(sem_host_pkg::OP_TRY, 3'h2, 1'b1);
        check("pending", {8'h0, pending_out}, 16'h0004);
        r_write(3'h2, 1'b1);
        host_rd(sem_host_pkg::OP_READ, 3'h2, 1'b0);
        check("held", {8'h0, held_out}, 16'h0004);
        host(sem_host_pkg::OP_RELEASE, 3'h2);
        check("pending", {8'h0, pending_out}, 16'h0000);
        check("held", {8'h0, held_out}, 16'h0000);
        r_read(3'h2, 1'b1);
        host_rd(sem_host_pkg::OP_TRY, 3'h5, 1'b0);
        // right queues a request while the host owns the flag
        r_write(3'h5, 1'b0);
        r_open(3'h5);
        check("right open", r_q, 16'hffff);
        host_rd(sem_host_pkg::OP_READ, 3'h5, 1'b0);
        // ownership passes during the open read: latched value must hold
        host(sem_host_pkg::OP_RELEASE, 3'h5);
        check("right held", r_q, 16'hffff);
        r_close();
        r_read(3'h5, 1'b0);
        r_write(3'h5, 1'b1);
        r_read(3'h5, 1'b1);
        final_report();
    end
endmodule : dual_port_semaphore_flags_bench
